//--- verilog/multiphase_pwm_timing.sv
// Top of the interleaved PWM timing core: phase timing, straps, sampling, registers.
// Assumes ramp crossings and sense values are synchronous digital inputs.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timing_regs.svh"
module multiphase_pwm_timing import pwm_timing_pkg::*; (
   input  wire logic        clk,                        // 125 MHz clock
   input  wire logic        nrst,                       // Async reset, low
   input  wire logic [7:0]  reg_addr,                   // Register byte address
   input  wire logic [31:0] reg_wdata,                  // Register write data
   input  wire logic        reg_wr,                     // Write strobe
   input  wire logic        reg_rd,                     // Read strobe
   output logic [31:0]      reg_rdata,                  // Read data, next cycle
   input  wire logic [4:0]  voltage_select_code,        // Voltage select inputs
   input  wire logic [3:0]  ramp_cross,                 // Corrected error above ramp
   input  wire sample_type  phase_current_sense_input_1, // Phase 1 sense
   input  wire sample_type  phase_current_sense_input_2, // Phase 2 sense
   input  wire sample_type  phase_current_sense_input_3, // Phase 3 sense
   input  wire sample_type  phase_current_sense_input_4, // Phase 4 sense
   output logic             phase_out_1,                // Phase 1 level
   output logic             phase_out_1_oe,             // Phase 1 drive enable
   output logic             phase_out_2,                // Phase 2 level
   output logic             phase_out_2_oe,             // Phase 2 drive enable
   input  wire logic        phase_out_3_count_strap_i,  // Phase 3 pin level
   output logic             phase_out_3_count_strap_o,  // Phase 3 level
   output logic             phase_out_3_count_strap_oe, // Phase 3 drive enable
   input  wire logic        phase_out_4_count_strap_i,  // Phase 4 pin level
   output logic             phase_out_4_count_strap_o,  // Phase 4 level
   output logic             phase_out_4_count_strap_oe, // Phase 4 drive enable
   output logic [3:0]       sample_strobe,              // Sample-and-hold pulses
   output sample_type       mean_phase_current,         // Mean of active samples
   output imbalance_type    phase_imbalance_current [4], // Per-phase imbalance
   output logic [10:0]      reference_mv,               // Reference level
   output logic             shutdown                    // Shutdown state
);

   // Registers and state
   run_state_type state_q;
   run_state_type state_d;
   logic [15:0]   len_q;
   logic [15:0]   settle_q;
   logic [15:0]   len_run_q;
   logic [15:0]   settle_run_q;
   logic [15:0]   cyc_q;
   logic [7:0]    wait_q;
   logic [2:0]    nphase_q;
   logic [3:0]    active_q;
   logic [3:0]    pwm_q;
   logic [3:0]    oe_q;
   logic [3:0]    blank_q;
   logic [15:0]   foff_q [4];
   sample_type    hold_q [4];
   logic [3:0]    strobe_q;
   logic [31:0]   rdata_q;
   logic          shut_out_q;

   // Submodule outputs
   logic          vid_shut;
   logic [4:0]    ref_code;
   logic [10:0]   ref_mv;
   sample_type    mean_cur;
   imbalance_type err_cur [4];

   // Strap decode from floating pins
   function automatic logic [2:0] strap_count(input logic p3, input logic p4);
      if (p3)
         strap_count = 3'h2;
      else if (p4)
         strap_count = 3'h3;
      else
         strap_count = 3'h4;
   endfunction

   function automatic logic [3:0] count_mask(input logic [2:0] n);
      case (n)
         3'h2:    count_mask = 4'h3;
         3'h3:    count_mask = 4'h7;
         default: count_mask = 4'hf;
      endcase
   endfunction

   // Spacing between successive terminations
   // Three phases use a fixed-point third of the length
   function automatic logic [15:0] phase_step(input logic [2:0] n, input logic [15:0] len);
      logic [31:0] prod;
      prod = {16'h0000, len} * {16'h0000, `THIRD_MUL};
      case (n)
         3'h2:    phase_step = {1'b0, len[15:1]};
         3'h3:    phase_step = prod[31:16];
         default: phase_step = {2'b00, len[15:2]};
      endcase
   endfunction

   function automatic logic [15:0] clamp_len(input logic [15:0] v);
      clamp_len = (v < `CYCLE_LEN_MIN) ? `CYCLE_LEN_MIN : v;
   endfunction

   // Register decode
   wire        hit_len    = (reg_addr == `REG_CYCLE_LEN);
   wire        hit_settle = (reg_addr == `REG_SETTLE);
   wire        hit_status = (reg_addr == `REG_STATUS);
   wire        wr_len     = reg_wr && hit_len;
   wire        wr_settle  = reg_wr && hit_settle;
   wire [31:0] status_word = {19'h00000,
                              ref_code,
                              1'b0,
                              vid_shut,
                              state_q,
                              nphase_q};
   wire [31:0] rdata_d = !reg_rd    ? 32'h00000000 :
                         hit_len    ? {16'h0000, len_q} :
                         hit_settle ? {16'h0000, settle_q} :
                         hit_status ? status_word :
                         32'h00000000;

   // Timing decode
   wire        running   = (state_q == ST_RUN);
   wire [15:0] step      = phase_step(nphase_q, len_run_q);
   wire [15:0] quarter   = {2'b00, len_run_q[15:2]};
   wire [15:0] off_1     = step;
   wire [15:0] off_2     = 16'(step + step);
   wire [15:0] off_3     = 16'(off_2 + step);
   wire        cyc_wrap  = (cyc_q == 16'(len_run_q - 16'h0001));
   wire [15:0] cyc_d     = (!running || cyc_wrap) ? 16'h0000 : 16'(cyc_q + 16'h0001);
   wire [3:0]  term;
   wire        cycle_start;
   wire        strap_done = (wait_q == 8'(`STRAP_WAIT_CYC));
   wire [2:0]  strap_n    = strap_count(phase_out_3_count_strap_i, phase_out_4_count_strap_i);

   // Sense inputs gathered by phase index
   sample_type sense_in [4];
   assign sense_in[0] = phase_current_sense_input_1;
   assign sense_in[1] = phase_current_sense_input_2;
   assign sense_in[2] = phase_current_sense_input_3;
   assign sense_in[3] = phase_current_sense_input_4;

   assign term[0] = running && active_q[0] && (cyc_q == 16'h0000);
   assign term[1] = running && active_q[1] && (cyc_q == off_1);
   assign term[2] = running && active_q[2] && (cyc_q == off_2);
   assign term[3] = running && active_q[3] && (cyc_q == off_3);
   assign cycle_start = term[0];

   // Per-phase next state
   // Termination takes priority over blanking and the ramp
   logic [3:0]  pwm_d;
   logic [3:0]  blank_d;
   logic [3:0]  strobe_d;
   logic [15:0] foff_d [4];
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         pwm_d[k]    = pwm_q[k];
         blank_d[k]  = blank_q[k];
         foff_d[k]   = foff_q[k];
         strobe_d[k] = 1'b0;
         if (!running || !active_q[k]) begin
            pwm_d[k]   = 1'b0;
            blank_d[k] = 1'b0;
            foff_d[k]  = 16'h0000;
         end else if (term[k]) begin
            pwm_d[k]   = 1'b0;
            blank_d[k] = 1'b1;
            foff_d[k]  = 16'h0000;
         end else if (blank_q[k]) begin
            foff_d[k] = 16'(foff_q[k] + 16'h0001);
            strobe_d[k] = (foff_q[k] == settle_run_q);
            if (foff_d[k] >= quarter)
               blank_d[k] = 1'b0;
         end else if (!pwm_q[k] && ramp_cross[k]) begin
            pwm_d[k] = 1'b1;
         end
      end
   end

   // Run sequencing
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_STRAP: begin
            if (vid_shut)
               state_d = ST_SHUT;
            else if (strap_done)
               state_d = ST_RUN;
         end
         ST_RUN: begin
            if (vid_shut)
               state_d = ST_SHUT;
         end
         ST_SHUT: begin
            if (!vid_shut)
               state_d = ST_STRAP;
         end
         default: state_d = ST_STRAP;
      endcase
   end

   // Sequencing register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         state_q <= ST_STRAP;
      else
         state_q <= state_d;
   end

   // Strap wait counts only while the pins float
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         wait_q <= 8'h00;
      else
         wait_q <= (state_q == ST_STRAP && !strap_done) ? 8'(wait_q + 8'h01) : 8'h00;
   end

   // Strap capture while pins float
   // Lengths written while running wait for the next restart
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         nphase_q     <= 3'h4;
         active_q     <= 4'h0;
         len_run_q    <= `CYCLE_LEN_RST;
         settle_run_q <= `SETTLE_RST;
      end else if (state_q == ST_STRAP && strap_done && !vid_shut) begin
         nphase_q     <= strap_n;
         active_q     <= count_mask(strap_n);
         len_run_q    <= len_q;
         settle_run_q <= settle_q;
      end else if (state_q != ST_RUN) begin
         active_q <= 4'h0;
      end
   end

   // Software registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         len_q    <= `CYCLE_LEN_RST;
         settle_q <= `SETTLE_RST;
      end else begin
         if (wr_len)
            len_q <= clamp_len(reg_wdata[15:0]);
         if (wr_settle)
            settle_q <= reg_wdata[15:0];
      end
   end

   // Read data stands for the one cycle after the strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         rdata_q <= 32'h00000000;
      else
         rdata_q <= rdata_d;
   end

   // Cycle counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         cyc_q <= 16'h0000;
      else
         cyc_q <= cyc_d;
   end

   // Phase outputs and drive enables
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pwm_q    <= 4'h0;
         oe_q     <= 4'h0;
         blank_q  <= 4'h0;
         strobe_q <= 4'h0;
      end else begin
         pwm_q    <= pwm_d;
         blank_q  <= blank_d;
         strobe_q <= strobe_d;
         oe_q     <= running ? active_q : 4'h0;
      end
   end

   // Forced off counters
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int k = 0; k < 4; k++)
            foff_q[k] <= 16'h0000;
      end else begin
         for (int k = 0; k < 4; k++)
            foff_q[k] <= foff_d[k];
      end
   end

   // Held samples; an inactive phase holds zero so the mean ignores it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int k = 0; k < 4; k++)
            hold_q[k] <= 10'h000;
      end else begin
         for (int k = 0; k < 4; k++)
            if (!active_q[k])
               hold_q[k] <= 10'h000;
            else if (strobe_d[k])
               hold_q[k] <= sense_in[k];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         shut_out_q <= 1'b0;
      else
         shut_out_q <= (state_d == ST_SHUT);
   end

   vid_reference u_vid (
      .clk         (clk),
      .nrst        (nrst),
      .cycle_start (cycle_start),
      .code        (voltage_select_code),
      .shut_q      (vid_shut),
      .ref_code_q  (ref_code),
      .ref_mv_q    (ref_mv)
   );

   current_balance u_bal (
      .clk    (clk),
      .nrst   (nrst),
      .active (active_q),
      .nphase (nphase_q),
      .hold   (hold_q),
      .mean_q (mean_cur),
      .err_q  (err_cur)
   );

   // Output mapping
   assign reg_rdata                  = rdata_q;
   assign phase_out_1                = pwm_q[0];
   assign phase_out_1_oe             = oe_q[0];
   assign phase_out_2                = pwm_q[1];
   assign phase_out_2_oe             = oe_q[1];
   assign phase_out_3_count_strap_o  = pwm_q[2];
   assign phase_out_3_count_strap_oe = oe_q[2];
   assign phase_out_4_count_strap_o  = pwm_q[3];
   assign phase_out_4_count_strap_oe = oe_q[3];
   assign sample_strobe              = strobe_q;
   assign mean_phase_current         = mean_cur;
   assign phase_imbalance_current    = err_cur;
   assign reference_mv               = ref_mv;
   assign shutdown                   = shut_out_q;

endmodule // multiphase_pwm_timing
`default_nettype wire

//--- verilog/pwm_timing_regs.svh
// Offsets, reset values, field positions and timing counts of the PWM timing core.
// Assumes a 125 MHz clock and a switching cycle programmed as a count of clocks.
`ifndef PWM_TIMING_REGS_SVH
`define PWM_TIMING_REGS_SVH

`define CLK_PERIOD_NS    8
`define STRAP_WAIT_NS    200
`define STRAP_WAIT_CYC   ((`STRAP_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define REG_CYCLE_LEN    8'h00
`define REG_SETTLE       8'h04
`define REG_STATUS       8'h08

`define CYCLE_LEN_RST    16'h0190
`define SETTLE_RST       16'h0010
`define CYCLE_LEN_MIN    16'h0010

`define ST_NPHASE_LSB    0
`define ST_STATE_LSB     3
`define ST_SHUT_BIT      6
`define ST_REF_LSB       8

`define VID_SHUTDOWN     5'h1f
`define VID_RST          5'h1e
`define VREF_TOP_MV      11'h60e
`define VREF_STEP_MV     11'h019
`define THIRD_MUL        16'h5556

`endif

//--- verilog/pwm_timing_pkg.sv
// Types shared by the PWM timing core and its helpers.
// Assumes the constants header is included where numbers are needed.
package pwm_timing_pkg;
   typedef enum logic [2:0] {
      ST_STRAP = 3'b001,
      ST_RUN   = 3'b010,
      ST_SHUT  = 3'b100
   } run_state_type;
   typedef logic [9:0]  sample_type;
   typedef logic [10:0] imbalance_type;
endpackage

//--- verilog/vid_reference.sv
// Voltage select decode and stepped reference tracking.
// Assumes cycle_start pulses once per switching cycle while running.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timing_regs.svh"
module vid_reference import pwm_timing_pkg::*; (
   input  wire logic        clk,          // System clock
   input  wire logic        nrst,         // Async reset, low
   input  wire logic        cycle_start,  // Start of switching cycle
   input  wire logic [4:0]  code,         // Voltage select code
   output logic             shut_q,       // Shutdown code present
   output logic [4:0]       ref_code_q,   // Present reference code
   output logic [10:0]      ref_mv_q      // Reference in millivolts
);
   logic [4:0] cand_q;
   logic [4:0] target_q;
   logic       half_q;
   wire        step_now = cycle_start && half_q && (ref_code_q != target_q);
   wire [4:0]  ref_code_d = (target_q > ref_code_q) ? ref_code_q + 5'h01 : ref_code_q - 5'h01;

   function automatic logic [10:0] code_to_mv(input logic [4:0] c);
      code_to_mv = `VREF_TOP_MV - 11'(`VREF_STEP_MV * {6'h00, c});
   endfunction

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shut_q     <= 1'b0;
         cand_q     <= `VID_RST;
         target_q   <= `VID_RST;
         half_q     <= 1'b0;
         ref_code_q <= `VID_RST;
         ref_mv_q   <= 11'h000;
      end else begin
         shut_q   <= (code == `VID_SHUTDOWN);
         ref_mv_q <= code_to_mv(ref_code_q);
         if (cycle_start) begin
            cand_q <= code;
            half_q <= ~half_q;
            if (code == cand_q && code != `VID_SHUTDOWN)
               target_q <= cand_q;
         end
         if (step_now)
            ref_code_q <= ref_code_d;
      end
   end
endmodule // vid_reference
`default_nettype wire

//--- verilog/current_balance.sv
// Mean current and per-phase imbalance from held samples.
// Assumes inactive phases hold zero samples and nphase is 2, 3 or 4.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timing_regs.svh"
module current_balance import pwm_timing_pkg::*; (
   input  wire logic           clk,      // System clock
   input  wire logic           nrst,     // Async reset, low
   input  wire logic [3:0]     active,   // Active phase mask
   input  wire logic [2:0]     nphase,   // Active phase count
   input  wire sample_type     hold [4], // Held samples
   output sample_type          mean_q,   // Mean current
   output imbalance_type       err_q [4] // Sample minus mean
);
   logic [11:0] sum;
   logic [27:0] third;
   sample_type  mean_d;
   always_comb begin
      sum = 12'h000;
      for (int k = 0; k < 4; k++)
         if (active[k]) sum = sum + {2'b00, hold[k]};
      third = {16'h0000, sum} * {12'h000, `THIRD_MUL};
      case (nphase)
         3'h2:    mean_d = sum[10:1];
         3'h3:    mean_d = third[25:16];
         default: mean_d = sum[11:2];
      endcase
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mean_q <= 10'h000;
         for (int k = 0; k < 4; k++) err_q[k] <= 11'h000;
      end else begin
         mean_q <= mean_d;
         for (int k = 0; k < 4; k++)
            err_q[k] <= active[k] ? ({1'b0, hold[k]} - {1'b0, mean_d}) : 11'h000;
      end
   end
endmodule // current_balance
`default_nettype wire

//--- verif/gate_driver_model.sv
// Far side of the phase pins: driver inputs and the board's phase-count ties.
// Assumes an undriven, untied pin sits at a weak pull-down.
`timescale 1ns/10ps
`default_nettype none
module gate_driver_model (
   input  wire logic tie3, // Board ties phase 3 pin high
   input  wire logic tie4, // Board ties phase 4 pin high
   input  wire logic o3,   // Device phase 3 level
   input  wire logic oe3,  // Device phase 3 enable
   input  wire logic o4,   // Device phase 4 level
   input  wire logic oe4,  // Device phase 4 enable
   output logic      pin3, // Resolved phase 3 wire
   output logic      pin4  // Resolved phase 4 wire
);
   // A tie to supply wins over the device
   assign pin3 = tie3 ? 1'b1 : (oe3 ? o3 : 1'b0);
   assign pin4 = tie4 ? 1'b1 : (oe4 ? o4 : 1'b0);
endmodule // gate_driver_model
`default_nettype wire

//--- verif/multiphase_pwm_timing_chk.sv
// Port checker for the PWM timing core.
// Assumes it is bound to the top module; QUARTER is the shortest forced off run.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timing_regs.svh"
module multiphase_pwm_timing_chk #(
   parameter int QUARTER = 12 // Forced off clocks
) (
   input wire logic        clk,                        // Clock
   input wire logic        nrst,                       // Reset, low
   input wire logic        phase_out_1,                // Phase 1
   input wire logic        phase_out_1_oe,             // Phase 1 enable
   input wire logic        phase_out_2,                // Phase 2
   input wire logic        phase_out_2_oe,             // Phase 2 enable
   input wire logic        phase_out_3_count_strap_oe, // Phase 3 enable
   input wire logic        phase_out_4_count_strap_oe, // Phase 4 enable
   input wire logic [3:0]  sample_strobe,              // Sample pulses
   input wire logic [10:0] reference_mv,               // Reference
   input wire logic        shutdown                    // Shutdown
);
   int low1_q;
   int low2_q;
   int oe_low_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low1_q   <= 0;
         low2_q   <= 0;
         oe_low_q <= 0;
      end else begin
         low1_q   <= phase_out_1 ? 0 : low1_q + 1;
         low2_q   <= phase_out_2 ? 0 : low2_q + 1;
         oe_low_q <= phase_out_1_oe ? 0 : oe_low_q + 1;
      end
   end
   forced_off_one_a: assert property ($rose(phase_out_1) |-> low1_q >= QUARTER)
      else $error("phase 1 off time short");
   forced_off_two_a: assert property ($rose(phase_out_2) |-> low2_q >= QUARTER)
      else $error("phase 2 off time short");
   shut_float_a: assert property (shutdown [*2] |-> !(phase_out_1_oe || phase_out_2_oe
      || phase_out_3_count_strap_oe || phase_out_4_count_strap_oe)) else $error("driven in shutdown");
   ref_step_a: assert property ($changed(reference_mv) && $past(reference_mv) != 0 |->
      reference_mv == $past(reference_mv) + 25 || reference_mv + 25 == $past(reference_mv))
      else $error("reference step not 25");
   ref_pace_a: assert property ($changed(reference_mv) && $past(reference_mv) != 0
      |=> $stable(reference_mv) [*8]) else $error("reference steps too fast");
   ref_grid_a: assert property (reference_mv != 0 |-> reference_mv >= 800
      && reference_mv <= 1550 && (1550 - reference_mv) % 25 == 0) else $error("reference off grid");
   sample_off_a: assert property (sample_strobe[0] |-> !phase_out_1 && phase_out_1_oe)
      else $error("sample outside off time");
   sample_inact_a: assert property (sample_strobe[3] |-> phase_out_4_count_strap_oe)
      else $error("sample on inactive phase");
   strap_float_a: assert property ($rose(phase_out_1_oe) |-> oe_low_q >= `STRAP_WAIT_CYC)
      else $error("drive before strap wait");
   cover property ($rose(shutdown));
   cover property (sample_strobe[2]);
   cover property ($changed(reference_mv));
endmodule // multiphase_pwm_timing_chk
`default_nettype wire

//--- verif/tb_multiphase_pwm_timing_vid_decode.sv
// Self-checking bench of the PWM timing core with strap modes and reference stepping.
// Assumes the constants header and package are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timing_regs.svh"
`define CHECK_EQ(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %s exp %0d got %0d", n, e, g); end end
module tb_multiphase_pwm_timing_vid_decode import pwm_timing_pkg::*;;
   localparam int LEN = 48;
   logic          clk = 1'b0;
   logic          nrst = 1'b0;
   logic [7:0]    reg_addr = 8'h00;
   logic [31:0]   reg_wdata = 32'h0;
   logic [31:0]   reg_rdata, rdat;
   logic          reg_wr = 1'b0;
   logic          reg_rd = 1'b0;
   logic [4:0]    vsel = 5'h00;
   logic [3:0]    ramp = 4'h0;
   wire logic [3:0] po, oe, strobe;
   sample_type    sense [4];
   sample_type    mean;
   imbalance_type imb [4];
   logic [10:0]   ref_mv;
   logic          shut, pin3, pin4;
   logic          tie3 = 1'b0;
   logic          tie4 = 1'b0;
   int            error_cnt = 0, compares = 0, tcnt = 0, np, step, prev1, v;
   int            fall_t [4];
   int            ts [3];
   always #4 clk = ~clk;
   always @(negedge clk) tcnt <= tcnt + 1;
   always @(posedge clk) ramp <= 4'($urandom);
   always @(negedge po[0]) begin
      prev1 = fall_t[0];
      fall_t[0] = tcnt;
   end
   always @(negedge po[1]) fall_t[1] = tcnt;
   always @(negedge po[2]) fall_t[2] = tcnt;
   always @(negedge po[3]) fall_t[3] = tcnt;
   multiphase_pwm_timing uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .voltage_select_code(vsel), .ramp_cross(ramp),
      .phase_current_sense_input_1(sense[0]), .phase_current_sense_input_2(sense[1]),
      .phase_current_sense_input_3(sense[2]), .phase_current_sense_input_4(sense[3]),
      .phase_out_1(po[0]), .phase_out_1_oe(oe[0]), .phase_out_2(po[1]), .phase_out_2_oe(oe[1]),
      .phase_out_3_count_strap_i(pin3), .phase_out_3_count_strap_o(po[2]),
      .phase_out_3_count_strap_oe(oe[2]), .phase_out_4_count_strap_i(pin4),
      .phase_out_4_count_strap_o(po[3]), .phase_out_4_count_strap_oe(oe[3]),
      .sample_strobe(strobe), .mean_phase_current(mean), .phase_imbalance_current(imb),
      .reference_mv(ref_mv), .shutdown(shut));
   gate_driver_model drv (.tie3(tie3), .tie4(tie4), .o3(po[2]), .oe3(oe[2]),
      .o4(po[3]), .oe4(oe[3]), .pin3(pin3), .pin4(pin4));
   task automatic print_verdict();
      $display("counts: compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask
   // Selector 0 shutdown, 1 phase 1 enable, 2 reference
   task automatic wait_until(input int sel, input int val);
      int i;
      for (i = 0; i < 8000; i++) begin
         if ((sel == 0 && shut === val[0]) || (sel == 1 && oe[0] === val[0])
            || (sel == 2 && ref_mv === val[10:0])) break;
         @(negedge clk);
      end
      if (i == 8000) begin
         $display("BAD wait %0d exp %0d got timeout", sel, val);
         error_cnt++;
         print_verdict();
      end
   endtask
   task automatic run_mode(input int m);
      int sum, mn, k;
      np = (m == 0) ? 4 : m + 1;
      step = (m == 0) ? LEN / 4 : (m == 1) ? LEN / 2 : (LEN * 32'h5556) >> 16;
      @(posedge clk);
      vsel <= `VID_SHUTDOWN;
      wait_until(0, 1);
      repeat (3) @(negedge clk);
      `CHECK_EQ("oe in shutdown", 0, oe)
      @(posedge clk);
      tie3 <= (m == 1);
      tie4 <= (m == 2);
      for (k = 0; k < 4; k++) sense[k] <= 10'($urandom);
      vsel <= 5'h00;
      wait_until(0, 0);
      wait_until(1, 1);
      repeat (4 * LEN) @(posedge clk);
      rd(`REG_STATUS, rdat);
      `CHECK_EQ("phase count", np, rdat[2:0])
      `CHECK_EQ("period", LEN, fall_t[0] - prev1)
      for (k = 1; k < np; k++)
         `CHECK_EQ("spacing", k * step, (fall_t[k] - fall_t[0] + LEN) % LEN)
      `CHECK_EQ("inactive oe", 0, oe >> np)
      sum = 0;
      for (k = 0; k < np; k++) sum += sense[k];
      mn = sum / np;
      `CHECK_EQ("mean", mn, mean)
      for (k = 0; k < 4; k++)
         `CHECK_EQ("imbalance", (k < np) ? imbalance_type'(sense[k] - mn) : 0, imb[k])
      $display("strap mode %0d done", m);
   endtask
   initial begin
      for (int k = 0; k < 4; k++) sense[k] = '0;
      void'($urandom(68));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rd(`REG_CYCLE_LEN, rdat);
      `CHECK_EQ("cycle len reset", `CYCLE_LEN_RST, rdat)
      rd(`REG_SETTLE, rdat);
      `CHECK_EQ("settle reset", `SETTLE_RST, rdat)
      rd(8'h0c, rdat);
      `CHECK_EQ("unmapped", 0, rdat)
      $display("register test done");
      wr(`REG_CYCLE_LEN, LEN);
      wr(`REG_SETTLE, 4);
      for (int m = 0; m < 3; m++) run_mode(m);
      wait_until(2, 1550);
      repeat (4 * LEN) @(posedge clk);
      `CHECK_EQ("ref code 0", 1550, ref_mv)
      rd(`REG_STATUS, rdat);
      `CHECK_EQ("ref code 0 status", 0, rdat[12:8])
      @(posedge clk);
      vsel <= 5'h1e;
      for (int k = 0; k < 3; k++) begin
         wait_until(2, 1525 - 25 * k);
         ts[k] = tcnt;
      end
      `CHECK_EQ("ref pace", 2 * LEN, ts[2] - ts[1])
      wait_until(2, 800);
      rd(`REG_STATUS, rdat);
      `CHECK_EQ("ref code 30", 30, rdat[12:8])
      v = $urandom % 31;
      @(posedge clk);
      vsel <= 5'(v);
      wait_until(2, 1550 - 25 * v);
      repeat (4 * LEN) @(posedge clk);
      `CHECK_EQ("ref random", 1550 - 25 * v, ref_mv)
      $display("reference test done");
      print_verdict();
   end
endmodule // tb_multiphase_pwm_timing_vid_decode
bind multiphase_pwm_timing multiphase_pwm_timing_chk #(.QUARTER(12)) chk (.clk(clk),
   .nrst(nrst), .phase_out_1(phase_out_1), .phase_out_1_oe(phase_out_1_oe),
   .phase_out_2(phase_out_2), .phase_out_2_oe(phase_out_2_oe),
   .phase_out_3_count_strap_oe(phase_out_3_count_strap_oe),
   .phase_out_4_count_strap_oe(phase_out_4_count_strap_oe), .sample_strobe(sample_strobe),
   .reference_mv(reference_mv), .shutdown(shutdown));
`default_nettype wire
